// *** include/scr_pkg.sv ***
// Package of offsets, fields, reset values and limits for the config bank.
`default_nettype none
package scr_pkg;
   // Register offsets.
   localparam logic [7:0] OFS_STATUS = 8'h00;
   localparam logic [7:0] OFS_CONFIG = 8'h40;
   localparam logic [7:0] OFS_BUS_ADDRESS = 8'h43;
   localparam logic [7:0] OFS_PRESSURE_UNIT = 8'h44;
   localparam logic [7:0] OFS_PRESSURE_DIGITS = 8'h47;
   localparam logic [7:0] OFS_TEMPERATURE_UNIT = 8'h4d;
   localparam logic [7:0] OFS_TEMPERATURE_DIGITS = 8'h50;
   // Field positions.
   localparam int STATUS_ERR_BIT = 4;
   localparam int CFG_TYPE_BIT = 0;
   localparam int CFG_ORDER_BIT = 1;
   localparam int CFG_MODE_LSB = 2;
   localparam int CFG_RESTORE_BIT = 4;
   localparam int CFG_APPLY_BIT = 7;
   // Reset values.
   localparam logic [6:0] RST_BUS_ADDRESS = 7'h28;
   localparam logic [4:0] RST_CONFIG = 5'h00;
   localparam logic [7:0] RST_PRESSURE_UNIT = 8'h07;
   localparam logic [7:0] RST_TEMPERATURE_UNIT = 8'h20;
   // Digit count that marks an unrepresentable range, and the largest valid count.
   localparam logic [7:0] DIGITS_INVALID = 8'hff;
   localparam logic [7:0] DIGITS_MAX = 8'h05;
   // Largest magnitude, in units of 1e-3, that fits 16 bits with n digits.
   // Thousandths let a 32-bit range exceed every count, so the error case
   // is reachable; units of 1e-5 or finer would make it impossible.
   localparam logic [32:0] LIMIT_D5 = 33'h000000147;
   localparam logic [32:0] LIMIT_D4 = 33'h000000ccc;
   localparam logic [32:0] LIMIT_D3 = 33'h000007fff;
   localparam logic [32:0] LIMIT_D2 = 33'h00004fff6;
   localparam logic [32:0] LIMIT_D1 = 33'h00031ff9c;
   localparam logic [32:0] LIMIT_D0 = 33'h001f3fc18;

   function automatic logic pressure_code_ok(input logic [7:0] c);
      pressure_code_ok = (c >= 8'h01 && c <= 8'h0e) || c == 8'h91 ||
         (c >= 8'haa && c <= 8'hae) || (c >= 8'hb0 && c <= 8'hb3) ||
         (c >= 8'hed && c <= 8'hef);
   endfunction

   function automatic logic temperature_code_ok(input logic [7:0] c);
      temperature_code_ok = c >= 8'h20 && c <= 8'h23;
   endfunction
endpackage
`default_nettype wire

// *** rtl/scr_digits_calc.sv ***
// Decimal-place calculator for the pressure and temperature nominal ranges.
`default_nettype none
module scr_digits_calc
   import scr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic signed [31:0] p_lower,
   input wire logic signed [31:0] p_upper,
   input wire logic signed [31:0] t_lower,
   input wire logic signed [31:0] t_upper,
   output logic [7:0] p_digits,
   output logic [7:0] t_digits
);
   logic [7:0] next_p_digits;
   logic [7:0] next_t_digits;

   // A 33-bit magnitude keeps the most negative input from wrapping.
   function automatic logic [32:0] magnitude(input logic signed [31:0] v);
      logic [32:0] ext;
      ext = {v[31], v};
      magnitude = v[31] ? 33'(-ext) : ext;
   endfunction

   function automatic logic [7:0] digits(input logic signed [31:0] lo,
                                         input logic signed [31:0] hi);
      logic [32:0] m;
      m = magnitude(lo) > magnitude(hi) ? magnitude(lo) : magnitude(hi);
      if (m <= LIMIT_D5) digits = DIGITS_MAX;
      else if (m <= LIMIT_D4) digits = 8'h04;
      else if (m <= LIMIT_D3) digits = 8'h03;
      else if (m <= LIMIT_D2) digits = 8'h02;
      else if (m <= LIMIT_D1) digits = 8'h01;
      else if (m <= LIMIT_D0) digits = 8'h00;
      else digits = DIGITS_INVALID;
   endfunction

   always_comb begin
      next_p_digits = digits(p_lower, p_upper); // R8
      next_t_digits = digits(t_lower, t_upper); // R8
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         p_digits <= 8'h00;
         t_digits <= 8'h00;
      end else begin
         p_digits <= next_p_digits;
         t_digits <= next_t_digits;
      end
   end
endmodule
`default_nettype wire

// *** rtl/scr_config_regs.sv ***
// Configuration register bank: bus address, unit codes and digit counts.
//
// Behaviour
// R1: Bus address register, readable and writable, bits 7:1.
// R2: New address active only after apply bit.
// R3: Pressure unit accepts only defined codes.
// R4: Temperature unit accepts only codes 0x20-0x23.
// R5: Undefined unit code write is not acknowledged.
// R6: Unrepresentable range in integer mode sets error, digits read 0xff.
// R7: Digit registers read-only, meaningful in integer mode.
// R8: Digits computed from nominal ranges automatically.
// R9: Config bit 7 one applies pending address.
// R10: Status bit 4 shows error flag.
// R11: Refused unit write keeps previous valid code.
`default_nettype none
module scr_config_regs
   import scr_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rst,
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic reg_ack,
   output logic [7:0] reg_rdata,
   input wire logic signed [31:0] nom_p_lower,
   input wire logic signed [31:0] nom_p_upper,
   input wire logic signed [31:0] nom_t_lower,
   input wire logic signed [31:0] nom_t_upper,
   input wire logic fault_in,
   output logic [6:0] bus_address,
   output logic cfg_int_type,
   output logic cfg_high_first,
   output logic [1:0] cfg_mode,
   output logic cfg_restore,
   output logic err_flag
);
   logic [6:0] pending_address;
   logic [4:0] config_bits;
   logic [7:0] pressure_unit;
   logic [7:0] temperature_unit;
   logic [6:0] next_pending_address;
   logic [6:0] next_bus_address;
   logic [4:0] next_config_bits;
   logic [7:0] next_pressure_unit;
   logic [7:0] next_temperature_unit;
   logic [7:0] next_rdata;
   logic [7:0] next_status;
   logic [7:0] p_calc;
   logic [7:0] t_calc;
   logic [7:0] p_shown;
   logic [7:0] t_shown;
   logic range_bad;

   ////////////////////////////////////////////////////////////////////////
   scr_digits_calc u_digits (
      .sys_clk(sys_clk),
      .rst(rst),
      .p_lower(nom_p_lower),
      .p_upper(nom_p_upper),
      .t_lower(nom_t_lower),
      .t_upper(nom_t_upper),
      .p_digits(p_calc),
      .t_digits(t_calc)
   );

   ////////////////////////////////////////////////////////////////////////
   // The acknowledge is combinational so the bus engine can answer in the
   // same bit slot; unmapped and read-only writes are also refused.
   always_comb begin
      case (reg_addr)
         OFS_CONFIG, OFS_BUS_ADDRESS: reg_ack = reg_wr;
         OFS_PRESSURE_UNIT:
            reg_ack = reg_wr && pressure_code_ok(reg_wdata); // R3 R5
         OFS_TEMPERATURE_UNIT:
            reg_ack = reg_wr && temperature_code_ok(reg_wdata); // R4 R5
         default: reg_ack = 1'b0;
      endcase
   end

   always_comb begin
      next_pending_address = pending_address;
      next_bus_address = bus_address;
      next_config_bits = config_bits;
      next_pressure_unit = pressure_unit;
      next_temperature_unit = temperature_unit;
      if (reg_wr && reg_ack) begin
         case (reg_addr)
            OFS_BUS_ADDRESS: next_pending_address = reg_wdata[7:1]; // R1
            OFS_CONFIG: begin
               next_config_bits = reg_wdata[4:0];
               if (reg_wdata[CFG_APPLY_BIT])
                  next_bus_address = pending_address; // R2 R9
            end
            OFS_PRESSURE_UNIT: next_pressure_unit = reg_wdata; // R11
            OFS_TEMPERATURE_UNIT: next_temperature_unit = reg_wdata; // R11
            default: next_config_bits = config_bits;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         pending_address <= RST_BUS_ADDRESS;
         bus_address <= RST_BUS_ADDRESS;
         config_bits <= RST_CONFIG;
         pressure_unit <= RST_PRESSURE_UNIT;
         temperature_unit <= RST_TEMPERATURE_UNIT;
      end else begin
         pending_address <= next_pending_address;
         bus_address <= next_bus_address;
         config_bits <= next_config_bits;
         pressure_unit <= next_pressure_unit;
         temperature_unit <= next_temperature_unit;
      end
   end

   assign cfg_int_type = config_bits[CFG_TYPE_BIT];
   assign cfg_high_first = config_bits[CFG_ORDER_BIT];
   assign cfg_mode = config_bits[CFG_MODE_LSB +: 2];
   assign cfg_restore = config_bits[CFG_RESTORE_BIT];

   ////////////////////////////////////////////////////////////////////////
   // In float mode the counts carry no meaning and read as zero.
   always_comb begin
      p_shown = cfg_int_type ? p_calc : 8'h00; // R7
      t_shown = cfg_int_type ? t_calc : 8'h00; // R7
      range_bad = cfg_int_type &&
         (p_calc == DIGITS_INVALID || t_calc == DIGITS_INVALID); // R6
      err_flag = range_bad || fault_in; // R6 R10
      next_status = 8'h00;
      next_status[STATUS_ERR_BIT] = err_flag; // R10
      next_rdata = reg_rdata;
      if (reg_rd) begin
         case (reg_addr)
            OFS_STATUS: next_rdata = next_status;
            OFS_CONFIG: next_rdata = {3'h0, config_bits};
            OFS_BUS_ADDRESS: next_rdata = {pending_address, 1'b0}; // R1
            OFS_PRESSURE_UNIT: next_rdata = pressure_unit;
            OFS_PRESSURE_DIGITS: next_rdata = p_shown; // R7
            OFS_TEMPERATURE_UNIT: next_rdata = temperature_unit;
            OFS_TEMPERATURE_DIGITS: next_rdata = t_shown; // R7
            default: next_rdata = 8'h00;
         endcase
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst)
         reg_rdata <= 8'h00;
      else
         reg_rdata <= next_rdata;
   end

   ////////////////////////////////////////////////////////////////////////
   // Checks kept beside the logic.
   sequence addr_written_s;
      reg_wr && reg_addr == OFS_BUS_ADDRESS;
   endsequence

   sequence apply_written_s;
      reg_wr && reg_addr == OFS_CONFIG && reg_wdata[CFG_APPLY_BIT];
   endsequence

   addr_written_a: assert property ( // R1
      @(posedge sys_clk) disable iff (rst)
      addr_written_s |=> pending_address == $past(reg_wdata[7:1]))
      else $error("bus address write not stored");

   addr_apply_a: assert property ( // R2
      @(posedge sys_clk) disable iff (rst)
      apply_written_s |=> bus_address == $past(pending_address))
      else $error("applied address differs from written one");

   addr_hold_a: assert property ( // R9
      @(posedge sys_clk) disable iff (rst)
      !(reg_wr && reg_addr == OFS_CONFIG && reg_wdata[CFG_APPLY_BIT]) |=>
      $stable(bus_address))
      else $error("active address moved without apply");

   press_refuse_a: assert property ( // R3 R5 R11
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == OFS_PRESSURE_UNIT &&
      !pressure_code_ok(reg_wdata) |-> !reg_ack ##1 $stable(pressure_unit))
      else $error("bad pressure code taken");

   press_accept_a: assert property ( // R3
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == OFS_PRESSURE_UNIT && reg_wdata == 8'hef |->
      reg_ack ##1 pressure_unit == 8'hef)
      else $error("valid pressure code refused");

   temp_unit_a: assert property ( // R4 R5
      @(posedge sys_clk) disable iff (rst)
      reg_wr && reg_addr == OFS_TEMPERATURE_UNIT |->
      reg_ack == (reg_wdata[7:2] == 6'h08))
      else $error("temperature code check wrong");

   temp_keep_a: assert property ( // R11
      @(posedge sys_clk) disable iff (rst)
      ##1 temperature_unit >= 8'h20 && temperature_unit <= 8'h23)
      else $error("temperature unit holds an undefined code");

   range_error_a: assert property ( // R6
      @(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == OFS_PRESSURE_DIGITS && cfg_int_type &&
      p_calc == DIGITS_INVALID |=> reg_rdata == 8'hff && err_flag)
      else $error("bad range not flagged");

   float_digits_a: assert property ( // R7
      @(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == OFS_TEMPERATURE_DIGITS && !cfg_int_type |=>
      reg_rdata == 8'h00)
      else $error("digits shown in float mode");

   digits_ro_a: assert property ( // R7
      @(posedge sys_clk) disable iff (rst)
      reg_wr && (reg_addr == OFS_PRESSURE_DIGITS ||
      reg_addr == OFS_TEMPERATURE_DIGITS) |-> !reg_ack)
      else $error("write to read-only digits acknowledged");

   digits_calc_a: assert property ( // R8
      @(posedge sys_clk) disable iff (rst)
      nom_p_upper == 32'sd0 && nom_p_lower >= -32'sd327 &&
      nom_p_lower <= 32'sd327 ##1 1 |-> p_calc == 8'h05)
      else $error("digit count not computed");

   status_err_a: assert property ( // R10
      @(posedge sys_clk) disable iff (rst)
      reg_rd && reg_addr == OFS_STATUS |=>
      reg_rdata[STATUS_ERR_BIT] == $past(err_flag) && reg_rdata[7:5] == 3'h0)
      else $error("status error bit wrong");
endmodule
`default_nettype wire

// *** tb/scr_reg_master.sv ***
// Model of the bus engine that issues register byte reads and writes.
`default_nettype none
module scr_reg_master (
   input wire logic sys_clk,
   input wire logic reg_ack,
   input wire logic [7:0] reg_rdata,
   output logic reg_wr,
   output logic reg_rd,
   output logic [7:0] reg_addr,
   output logic [7:0] reg_wdata
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = 8'h00;
      reg_wdata = 8'h00;
   end
   // A strobe rises after a falling edge and drops one falling edge later.
   task automatic wr(input logic [7:0] a, input logic [7:0] d,
                     output logic k);
      @(negedge sys_clk);
      reg_wr = 1'b1;
      reg_addr = a;
      reg_wdata = d;
      @(posedge sys_clk);
      k = reg_ack;
      @(negedge sys_clk);
      reg_wr = 1'b0;
      // Released data is inverted so it differs from the byte just written.
      reg_wdata = ~d;
   endtask
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge sys_clk);
      reg_rd = 1'b1;
      reg_addr = a;
      @(posedge sys_clk);
      @(negedge sys_clk);
      reg_rd = 1'b0;
      d = reg_rdata;
   endtask
endmodule
`default_nettype wire

// *** tb/tb.sv ***
// Self-checking bench for the configuration register bank.
`default_nettype none
module tb
   import scr_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   logic sys_clk, rst, reg_wr, reg_rd, reg_ack, fault_in, err_flag;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   logic signed [31:0] nom_p_lower, nom_p_upper, nom_t_lower, nom_t_upper;
   logic [6:0] bus_address;
   logic cfg_int_type;
   logic cfg_high_first, cfg_restore;
   logic [1:0] cfg_mode;
   int err_count = 0;
   int checks = 0;
   scr_config_regs i_scr_config_regs (.sys_clk(sys_clk), .rst(rst),
      .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_addr(reg_addr),
      .reg_wdata(reg_wdata), .reg_ack(reg_ack), .reg_rdata(reg_rdata),
      .nom_p_lower(nom_p_lower), .nom_p_upper(nom_p_upper),
      .nom_t_lower(nom_t_lower), .nom_t_upper(nom_t_upper),
      .fault_in(fault_in), .bus_address(bus_address),
      .cfg_int_type(cfg_int_type), .cfg_high_first(cfg_high_first),
      .cfg_mode(cfg_mode), .cfg_restore(cfg_restore), .err_flag(err_flag));
   scr_reg_master i_scr_reg_master (.sys_clk(sys_clk), .reg_ack(reg_ack),
      .reg_rdata(reg_rdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
      .reg_addr(reg_addr), .reg_wdata(reg_wdata));
   ////////////////////////////////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      forever #25 sys_clk = ~sys_clk;
   end
   task automatic chk(input logic [7:0] got, input logic [7:0] exp);
      checks++;
      if (got !== exp) begin
         err_count++;
         $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic close_out();
      $display("checks=%0d err_count=%0d", checks, err_count);
      if (err_count == 0 && checks > 0)
         $display("NO MISMATCHES");
      else
         $display("MISMATCHES SEEN");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic wchk(input logic [7:0] a, input logic [7:0] d,
                       input logic e);
      logic k;
      i_scr_reg_master.wr(a, d, k);
      chk({7'h00, k}, {7'h00, e});
   endtask
   task automatic rchk(input logic [7:0] a, input logic [7:0] e);
      logic [7:0] d;
      i_scr_reg_master.rd(a, d);
      chk(d, e);
   endtask
   task automatic reset_values();
      chk({1'b0, bus_address}, 8'h28);
      rchk(OFS_BUS_ADDRESS, 8'h50);
      rchk(OFS_STATUS, 8'h00);
      wchk(8'h60, 8'h12, 1'b0);
      rchk(8'h60, 8'h00);
   endtask
   // The master writes the address first and only then the apply bit.
   task automatic address_change();
      wchk(OFS_BUS_ADDRESS, 8'h86, 1'b1);
      chk({1'b0, bus_address}, 8'h28);
      rchk(OFS_BUS_ADDRESS, 8'h86);
      wchk(OFS_CONFIG, 8'h00, 1'b1);
      chk({1'b0, bus_address}, 8'h28);
      wchk(OFS_CONFIG, 8'h80, 1'b1);
      chk({1'b0, bus_address}, 8'h43);
      rchk(OFS_CONFIG, 8'h00);
      wchk(OFS_CONFIG, 8'h7e, 1'b1);
      chk({5'h00, cfg_restore, cfg_mode}, 8'h07);
      chk({7'h00, cfg_high_first}, 8'h01);
      chk({1'b0, bus_address}, 8'h43);
      rchk(OFS_CONFIG, 8'h1e);
      wchk(OFS_CONFIG, 8'h00, 1'b1);
   endtask
   // Every byte value is offered so each defined code is accepted once.
   task automatic unit_sweep(input logic [7:0] a, input logic temp);
      logic ok;
      logic [7:0] keep;
      keep = temp ? 8'h20 : 8'h07;
      for (int c = 0; c < 256; c++) begin
         ok = temp ? c inside {[32'h20:32'h23]} : c inside {[32'h01:32'h0e],
            32'h91, [32'haa:32'hae], [32'hb0:32'hb3], [32'hed:32'hef]};
         wchk(a, c[7:0], ok);
         if (ok)
            keep = c[7:0];
         rchk(a, keep);
      end
   endtask
   task automatic digits();
      nom_p_lower = -32'sd32768;
      nom_p_upper = 32'sd100000;
      nom_t_lower = -32'sd500000;
      nom_t_upper = 32'sd1500000;
      wchk(OFS_CONFIG, 8'h01, 1'b1);
      chk({7'h00, cfg_int_type}, 8'h01);
      rchk(OFS_PRESSURE_DIGITS, 8'h02);
      rchk(OFS_TEMPERATURE_DIGITS, 8'h01);
      chk({7'h00, err_flag}, 8'h00);
      nom_p_lower = 32'sd32767;
      rchk(OFS_PRESSURE_DIGITS, 8'h02);
      nom_p_upper = 32'sd0;
      rchk(OFS_PRESSURE_DIGITS, 8'h03);
      nom_p_lower = 32'sd328;
      rchk(OFS_PRESSURE_DIGITS, 8'h04);
      nom_p_lower = -32'sd327;
      rchk(OFS_PRESSURE_DIGITS, 8'h05);
      wchk(OFS_PRESSURE_DIGITS, 8'h01, 1'b0);
      rchk(OFS_PRESSURE_DIGITS, 8'h05);
      nom_p_upper = 32'sd32767001;
      rchk(OFS_PRESSURE_DIGITS, 8'hff);
      rchk(OFS_STATUS, 8'h10);
      chk({7'h00, err_flag}, 8'h01);
      wchk(OFS_CONFIG, 8'h00, 1'b1);
      chk({7'h00, err_flag}, 8'h00);
      rchk(OFS_PRESSURE_DIGITS, 8'h00);
      nom_p_upper = 32'sd0;
      rchk(OFS_TEMPERATURE_DIGITS, 8'h00);
      fault_in = 1'b1;
      rchk(OFS_STATUS, 8'h10);
      chk({7'h00, err_flag}, 8'h01);
      fault_in = 1'b0;
   endtask
   ////////////////////////////////////////////////////////////////////
   // The sweeps take about two thousand cycles; this leaves ample slack.
   initial begin
      repeat (20000) @(posedge sys_clk);
      err_count++;
      close_out();
   end
   initial begin
      rst = 1'b1;
      fault_in = 1'b0;
      nom_p_lower = 32'sd0;
      nom_p_upper = 32'sd0;
      nom_t_lower = 32'sd0;
      nom_t_upper = 32'sd0;
      repeat (21) @(negedge sys_clk);
      rst = 1'b0;
      reset_values();
      address_change();
      unit_sweep(OFS_PRESSURE_UNIT, 1'b0);
      unit_sweep(OFS_TEMPERATURE_UNIT, 1'b1);
      digits();
      close_out();
   end
endmodule
`default_nettype wire
